// *** rtl/vcp_color_post.v ***
// Vertex color back end: material tracking, index lighting, clamp,
// flat provoking vertex, clip interpolation, fixed-point output.
// Assumes one clock, AHB-Lite slave registers, inputs synchronous.
`timescale 1ns/100ps
`default_nettype none
`include "vcp_regs.vh"
module vcp_color_post #(
  parameter NUM_LIGHTS = 8,
  parameter M_BITS     = 8,
  parameter B_BITS     = 8,
  parameter IDX_BITS   = 8
) (
  input  wire                     sys_clk_i,
  input  wire                     reset_n_i,
  input  wire                     hsel_i,
  input  wire [31:0]              haddr_i,
  input  wire [1:0]               htrans_i,
  input  wire                     hwrite_i,
  input  wire [2:0]               hsize_i,
  input  wire [31:0]              hwdata_i,
  input  wire                     hready_i,
  output reg                      hreadyout_o,
  output reg  [31:0]              hrdata_o,
  output reg                      hresp_o,
  input  wire                     color_valid_i,
  input  wire [63:0]              color_i,
  input  wire                     vtx_valid_i,
  input  wire                     prim_begin_i,
  input  wire [3:0]               prim_type_i,
  input  wire                     area_pos_i,
  input  wire [63:0]              lit_front_i,
  input  wire [63:0]              lit_back_i,
  input  wire [63:0]              lit_sec_i,
  input  wire [NUM_LIGHTS*16-1:0] geo_diff_i,
  input  wire [NUM_LIGHTS*16-1:0] geo_spec_i,
  input  wire                     clip_gen_i,
  input  wire [15:0]              clip_t_i,
  input  wire [15:0]              clip_tlin_i,
  input  wire [63:0]              clip_c2_pri_i,
  input  wire [63:0]              clip_c2_sec_i,
  input  wire [15:0]              clip_c2_idx_i,
  input  wire [15:0]              attr_i,
  input  wire [15:0]              attr_c2_i,
  input  wire                     attr_noper_i,
  input  wire                     int_src_i,
  input  wire [4*B_BITS-1:0]      int_color_i,
  output reg                      out_valid_o,
  output reg  [63:0]              out_pri_o,
  output reg  [63:0]              out_sec_o,
  output reg  [IDX_BITS+3:0]      out_idx_o,
  output reg  [15:0]              out_attr_o,
  output reg                      out_fixed_o,
  output reg                      out_back_o,
  output reg                      flat_valid_o,
  output reg  [63:0]              flat_pri_o,
  output reg  [63:0]              flat_sec_o,
  output reg  [IDX_BITS+3:0]      flat_idx_o
);
  // Q3.12 product, truncated back to 16 bits
  function [15:0] mulq;
    input [15:0] a, b;
    reg signed [31:0] p;
    begin
      p = $signed(a) * $signed(b);
      mulq = p[27:12];
    end
  endfunction
  function [15:0] clampq;
    input [15:0] a;
    clampq = a[15] ? 16'h0000 : (a > `VCP_ONE) ? `VCP_ONE : a;
  endfunction
  // Interpolation of one component at a clip vertex
  function [15:0] lerpq;
    input [15:0] t, c1, c2;
    lerpq = mulq(t, c1) + mulq(`VCP_ONE - t, c2);
  endfunction
  // Clamped Q3.12 to k of k/(2^m-1), round to nearest
  function [15:0] tofix;
    input [15:0] a;
    reg [31:0] p;
    begin
      p = {16'h0000, a} * ((32'h1 << M_BITS) - 32'h1) + `VCP_HALF;
      tofix = p[27:12] & ((16'h1 << M_BITS) - 16'h1);
    end
  endfunction
  // Integer source: top bits kept, low bits filled by replication
  function [15:0] intconv;
    input [B_BITS-1:0] v;
    integer k;
    begin
      intconv = 16'h0000;
      for (k = 0; k < M_BITS; k = k + 1)
        intconv[M_BITS-1-k] = v[B_BITS-1-(k % B_BITS)];
    end
  endfunction
  // Material defaults by property, same for back and front entries
  function [63:0] mat_def;
    input [1:0] p;
    begin
      case (p)
        2'h1:    mat_def = {`VCP_ONE, {3{`VCP_QTR_FIVE}}};
        2'h2:    mat_def = {`VCP_ONE, {3{`VCP_FOUR_FIVE}}};
        default: mat_def = {`VCP_ONE, 48'h0};
      endcase
    end
  endfunction
  // Light intensity as weighted sum of R, G, B
  function [15:0] lum;
    input [47:0] c;
    reg [31:0] s;
    begin
      s = {16'h0000, c[15:0]} * {16'h0000, `VCP_W_RED}
        + {16'h0000, c[31:16]} * {16'h0000, `VCP_W_GRN}
        + {16'h0000, c[47:32]} * {16'h0000, `VCP_W_BLU};
      lum = s[27:12];
    end
  endfunction
  reg  [31:0]           ctrl_q;
  reg  [2:0]            mat_sel_q;
  reg  [63:0]           mat_q [0:7];
  reg  [3:0]            lt_sel_q;
  reg  [47:0]           ldif_q [0:NUM_LIGHTS-1];
  reg  [47:0]           lspc_q [0:NUM_LIGHTS-1];
  reg  [NUM_LIGHTS-1:0] lt_en_q;
  reg  [15:0]           am_q, dm_q, sm_q, vcnt_q;
  reg  [63:0]           cur_q;
  reg  [1:0]            m3_q, m4_q;
  reg                   dph_q, dwr_q;
  reg  [7:0]            dadr_q;
  reg  [31:0]           rd_d;
  integer               i, j, k, n;
  wire       light_on = ctrl_q[`VCP_C_LIGHT];
  wire       track_on = ctrl_q[`VCP_C_TRACK];
  wire [1:0] clamp_md = ctrl_q[`VCP_C_CLAMP_LO+1:`VCP_C_CLAMP_LO];
  wire [2:0] prop     = ctrl_q[`VCP_C_PROP_LO+2:`VCP_C_PROP_LO];
  wire [1:0] face     = ctrl_q[`VCP_C_FACE_LO+1:`VCP_C_FACE_LO];
  wire       idx_md   = ctrl_q[`VCP_C_INDEX];
  // Which material entries follow the current color
  reg [7:0] tracked;
  always @*
    for (k = 0; k < 8; k = k + 1)
      tracked[k] = track_on && face[k/4] &&                // RULE_02
        ((prop == (k % 4)) ||                              // RULE_03
         (prop == `VCP_PROP_AMBDIF && ((k % 4) == 1 || (k % 4) == 2)));
  // Bus read mux, sampled one cycle after the address phase
  always @*
  begin
    rd_d = 32'h00000000;
    case (dadr_q)
      `VCP_CTRL_OFS:    rd_d = ctrl_q;
      `VCP_MAT_SEL_OFS: rd_d = {29'h0, mat_sel_q};
      `VCP_MAT_RG_OFS:  rd_d = mat_q[mat_sel_q][31:0];
      `VCP_MAT_BA_OFS:  rd_d = mat_q[mat_sel_q][63:32];
      `VCP_LT_SEL_OFS:  rd_d = {28'h0, lt_sel_q};
      `VCP_LT_RG_OFS:   rd_d = lt_sel_q[3] ? lspc_q[lt_sel_q[2:0]][31:0]
                                           : ldif_q[lt_sel_q[2:0]][31:0];
      `VCP_LT_B_OFS:    rd_d = {16'h0, lt_sel_q[3] ?
                                 lspc_q[lt_sel_q[2:0]][47:32] :
                                 ldif_q[lt_sel_q[2:0]][47:32]};
      `VCP_IDX_AM_OFS:  rd_d = {16'h0, am_q};
      `VCP_IDX_DM_OFS:  rd_d = {16'h0, dm_q};
      `VCP_IDX_SM_OFS:  rd_d = {16'h0, sm_q};
      `VCP_STATUS_OFS:  rd_d = {14'h0, m4_q, vcnt_q};
      `VCP_CUR_RG_OFS:  rd_d = cur_q[31:0];
      `VCP_CUR_BA_OFS:  rd_d = cur_q[63:32];
      `VCP_LT_EN_OFS:   rd_d[NUM_LIGHTS-1:0] = lt_en_q;
      default:          rd_d = 32'h00000000;
    endcase
  end
  // AHB-Lite slave: one wait state so reads see completed writes
  always @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      hreadyout_o <= 1'b1;
      hrdata_o    <= 32'h00000000;
      hresp_o     <= 1'b0;
      dph_q       <= 1'b0;
      dwr_q       <= 1'b0;
      dadr_q      <= 8'h00;
    end
    else
    begin
      if (hsel_i && htrans_i[1] && hready_i)
      begin
        dph_q       <= 1'b1;
        dwr_q       <= hwrite_i;
        dadr_q      <= {haddr_i[7:2], 2'b00};
        hreadyout_o <= 1'b0;
      end
      else if (dph_q)
      begin
        dph_q       <= 1'b0;
        hreadyout_o <= 1'b1;
        hrdata_o    <= dwr_q ? 32'h00000000 : rd_d;
      end
    end
  end
  wire wr = dph_q && dwr_q;
  // Lighting state, current color and material tracking
  always @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_q    <= `VCP_CTRL_RST;                         // RULE_07 RULE_13
      mat_sel_q <= 3'h0;
      lt_sel_q  <= 4'h0;
      lt_en_q   <= {NUM_LIGHTS{1'b0}};
      am_q      <= `VCP_IDX_AM_RST;                       // RULE_10
      dm_q      <= `VCP_IDX_DM_RST;
      sm_q      <= `VCP_IDX_SM_RST;
      cur_q     <= {`VCP_ONE, `VCP_ONE, `VCP_ONE, `VCP_ONE};
      for (j = 0; j < 8; j = j + 1)
        mat_q[j] <= mat_def(j[1:0]);
      for (j = 0; j < NUM_LIGHTS; j = j + 1)              // RULE_06
      begin
        ldif_q[j] <= (j == 0) ? {3{`VCP_ONE}} : 48'h0;
        lspc_q[j] <= (j == 0) ? {3{`VCP_ONE}} : 48'h0;
      end
    end
    else
    begin
      if (color_valid_i)
        cur_q <= color_i;
      if (wr)
      begin
        case (dadr_q)
          `VCP_CTRL_OFS:    ctrl_q    <= hwdata_i & 32'h00003FFF;
          `VCP_MAT_SEL_OFS: mat_sel_q <= hwdata_i[2:0];
          `VCP_LT_SEL_OFS:  lt_sel_q  <= hwdata_i[3:0];
          `VCP_LT_EN_OFS:   lt_en_q   <= hwdata_i[NUM_LIGHTS-1:0];
          `VCP_IDX_AM_OFS:  am_q      <= hwdata_i[15:0];
          `VCP_IDX_DM_OFS:  dm_q      <= hwdata_i[15:0];
          `VCP_IDX_SM_OFS:  sm_q      <= hwdata_i[15:0];
          default:          ;
        endcase
      end
      // Explicit material write loses to tracking on that entry
      for (j = 0; j < 8; j = j + 1)
      begin
        if (tracked[j])
          mat_q[j] <= color_valid_i ? color_i : cur_q; // RULE_01 RULE_05
        else if (wr && mat_sel_q == j && dadr_q == `VCP_MAT_RG_OFS)
          mat_q[j][31:0] <= hwdata_i;                     // RULE_04
        else if (wr && mat_sel_q == j && dadr_q == `VCP_MAT_BA_OFS)
          mat_q[j][63:32] <= hwdata_i;
      end
      for (j = 0; j < NUM_LIGHTS; j = j + 1)
      begin
        if (wr && lt_sel_q[2:0] == j && dadr_q == `VCP_LT_RG_OFS)
          if (lt_sel_q[3])
            lspc_q[j][31:0] <= hwdata_i;
          else
            ldif_q[j][31:0] <= hwdata_i;
        if (wr && lt_sel_q[2:0] == j && dadr_q == `VCP_LT_B_OFS)
          if (lt_sel_q[3])
            lspc_q[j][47:32] <= hwdata_i[15:0];
          else
            ldif_q[j][47:32] <= hwdata_i[15:0];
      end
    end
  end
  // Color index lighting
  reg [15:0] dsum, ssum, sp, cidx, lit_idx;
  always @*
  begin
    dsum = 16'h0000;
    ssum = 16'h0000;
    for (n = 0; n < NUM_LIGHTS; n = n + 1)
      if (lt_en_q[n])                                     // RULE_11 RULE_08
      begin
        dsum = dsum + mulq(geo_diff_i[n*16 +: 16], lum(ldif_q[n]));
        ssum = ssum + mulq(geo_spec_i[n*16 +: 16], lum(lspc_q[n]));
      end
    sp = ($signed(ssum) > $signed(`VCP_ONE)) ? `VCP_ONE : ssum; // RULE_09
    cidx = am_q + mulq(mulq(dsum, `VCP_ONE - sp), dm_q - am_q)
         + mulq(sp, sm_q - am_q);
    lit_idx = ($signed(cidx) > $signed(sm_q)) ? sm_q : cidx;
  end
  // Color selection, clamping, masking and clipping per vertex
  reg        use_back, clamp_on, is_prov;
  reg [1:0]  m3_nxt, m4_nxt;
  reg [15:0] k_nxt, idx_c, idx_r, idx_rf, attr_c;
  reg [63:0] pri_c, sec_c, pri_f, sec_f;
  always @*
  begin
    use_back = ctrl_q[`VCP_C_TWOSIDE] && prim_type_i >= `VCP_PT_POLYGON
             && (area_pos_i == ctrl_q[`VCP_C_CW]);       // RULE_24
    clamp_on = !idx_md && (clamp_md == `VCP_CLAMP_ON ||
               (clamp_md == `VCP_CLAMP_FIXED &&
                ctrl_q[`VCP_C_FBFIX]));                   // RULE_13
    // Primary from lighting or current color at this vertex
    pri_c = light_on ? (use_back ? lit_back_i : lit_front_i)
                     : cur_q;                             // RULE_18
    sec_c = light_on ? lit_sec_i : 64'h0;
    idx_c = light_on ? lit_idx : cur_q[15:0];
    for (i = 0; i < 4; i = i + 1)
    begin
      if (clamp_on)
      begin
        pri_c[i*16 +: 16] = clampq(pri_c[i*16 +: 16]);   // RULE_12
        sec_c[i*16 +: 16] = clampq(sec_c[i*16 +: 16]);
      end
      if (clip_gen_i)
      begin
        pri_c[i*16 +: 16] = lerpq(clip_t_i, pri_c[i*16 +: 16],
                                  clip_c2_pri_i[i*16 +: 16]); // RULE_19
        sec_c[i*16 +: 16] = lerpq(clip_t_i, sec_c[i*16 +: 16],
                                  clip_c2_sec_i[i*16 +: 16]);
      end
      if (!clamp_on)
      begin
        pri_f[i*16 +: 16] = pri_c[i*16 +: 16];
        sec_f[i*16 +: 16] = sec_c[i*16 +: 16];
      end
      else
      begin
        pri_f[i*16 +: 16] = (int_src_i && !light_on && !clip_gen_i)
          ? intconv(int_color_i[i*B_BITS +: B_BITS])      // RULE_22
          : tofix(pri_c[i*16 +: 16]);                     // RULE_21
        sec_f[i*16 +: 16] = tofix(sec_c[i*16 +: 16]);
      end
    end
    // Q8.8 is already fixed; rounding twice would bias the index
    idx_c = {idx_c[15:8] & ((8'h1 << IDX_BITS) - 8'h1),   // RULE_14
             idx_c[7:0]};
    idx_r = clip_gen_i ? lerpq(clip_t_i, idx_c, clip_c2_idx_i) : idx_c;
    idx_rf = idx_r + `VCP_IDX_RND;                        // RULE_23
    attr_c = clip_gen_i ? lerpq(attr_noper_i ? clip_tlin_i : clip_t_i,
                                attr_i, attr_c2_i) : attr_i; // RULE_20
    // Vertex number from 1, with modulo counters
    k_nxt  = prim_begin_i ? 16'h0001 : vcnt_q + 16'h0001;
    m3_nxt = (prim_begin_i || m3_q == 2'h2) ? (prim_begin_i ? 2'h1 : 2'h0)
                                            : m3_q + 2'h1;
    m4_nxt = prim_begin_i ? 2'h1 : m4_q + 2'h1;
    case (prim_type_i)                                    // RULE_16 RULE_17
      `VCP_PT_POINTS:  is_prov = 1'b1;
      `VCP_PT_LINES:   is_prov = !k_nxt[0];
      `VCP_PT_LSTRIP:  is_prov = k_nxt >= 16'h0002;
      `VCP_PT_POLYGON: is_prov = k_nxt == 16'h0001;
      `VCP_PT_TSTRIP,
      `VCP_PT_TFAN:    is_prov = k_nxt >= 16'h0003;
      `VCP_PT_TRIS:    is_prov = m3_nxt == 2'h0;
      `VCP_PT_QSTRIP:  is_prov = k_nxt >= 16'h0004 && !k_nxt[0];
      `VCP_PT_QUADS:   is_prov = m4_nxt == 2'h0;
      default:         is_prov = 1'b0;
    endcase
  end
  // Output stage: one cycle after the vertex is presented
  always @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      vcnt_q       <= 16'h0000;
      m3_q         <= 2'h0;
      m4_q         <= 2'h0;
      out_valid_o  <= 1'b0;
      out_pri_o    <= 64'h0;
      out_sec_o    <= 64'h0;
      out_idx_o    <= {(IDX_BITS+4){1'b0}};
      out_attr_o   <= 16'h0000;
      out_fixed_o  <= 1'b0;
      out_back_o   <= 1'b0;
      flat_valid_o <= 1'b0;
      flat_pri_o   <= 64'h0;
      flat_sec_o   <= 64'h0;
      flat_idx_o   <= {(IDX_BITS+4){1'b0}};
    end
    else
    begin
      out_valid_o  <= vtx_valid_i;
      // Per-primitive pulse; earlier vertices are already gone
      flat_valid_o <= vtx_valid_i && ctrl_q[`VCP_C_FLAT] && is_prov; // RULE_15
      if (vtx_valid_i)
      begin
        vcnt_q      <= k_nxt;
        m3_q        <= m3_nxt;
        m4_q        <= m4_nxt;
        out_pri_o   <= pri_f;
        out_sec_o   <= sec_f;
        out_idx_o   <= {idx_rf[8+IDX_BITS-1:8], idx_rf[7:4]};
        out_attr_o  <= attr_c;
        out_fixed_o <= clamp_on;
        out_back_o  <= use_back;
        if (ctrl_q[`VCP_C_FLAT] && is_prov)
        begin
          flat_pri_o <= pri_f;
          flat_sec_o <= sec_f;
          flat_idx_o <= {idx_rf[8+IDX_BITS-1:8], idx_rf[7:4]};
        end
      end
    end
  end
endmodule // vcp_color_post
`default_nettype wire

// *** rtl/vcp_regs.vh ***
// Constants for the vertex color post-processing block.
// Assumes a 32-bit AHB-Lite register bus; offsets are byte addresses.
//
// Functional notes
// RULE_01 - Tracking enabled copies current color into material
// RULE_02 - Tracking face: front, back or both
// RULE_03 - Tracking property: one, or ambient plus diffuse
// RULE_04 - Tracked values persist; untracked writes override
// RULE_05 - Selector change reloads material from current color
// RULE_06 - Keep materials, eight lights, enables, mode bits
// RULE_07 - Reset: defaults, features off, both faces ambdiff
// RULE_08 - Index intensities weight RGB .30 .59 .11
// RULE_09 - Cap specular sum, blend, cap index at sm
// RULE_10 - Index materials reset 0,1,1; RGBA unaffected
// RULE_11 - Disabled lights excluded from index sums
// RULE_12 - Clamp primary and secondary to [0,1] when active
// RULE_13 - Clamp control on/off/fixed-only, resets to on
// RULE_14 - Round index, mask integer part with 2^n-1
// RULE_15 - Shading mode bit: per-vertex or flat
// RULE_16 - Flat points own color, lines second vertex
// RULE_17 - Polygon provoking vertex per primitive type
// RULE_18 - Provoking color: current if unlit, else lit
// RULE_19 - Inside passes; clipped vertex gets t*c1+(1-t)*c2
// RULE_20 - Attributes clipped alike; noperspective uses linear t
// RULE_21 - Clamped components rounded to m-bit k/(2^m-1)
// RULE_22 - Integer-given unlit colors keep their top bits
// RULE_23 - Final index rounded, full index integer bits
// RULE_24 - Back color by area sign and winding bit
`ifndef VCP_REGS_VH
`define VCP_REGS_VH

// Register byte offsets
`define VCP_CTRL_OFS      8'h00
`define VCP_MAT_SEL_OFS   8'h04
`define VCP_MAT_RG_OFS    8'h08
`define VCP_MAT_BA_OFS    8'h0C
`define VCP_LT_SEL_OFS    8'h10
`define VCP_LT_RG_OFS     8'h14
`define VCP_LT_B_OFS      8'h18
`define VCP_IDX_AM_OFS    8'h1C
`define VCP_IDX_DM_OFS    8'h20
`define VCP_IDX_SM_OFS    8'h24
`define VCP_STATUS_OFS    8'h28
`define VCP_CUR_RG_OFS    8'h2C
`define VCP_CUR_BA_OFS    8'h30
`define VCP_LT_EN_OFS     8'h34

// Control register fields
`define VCP_C_LIGHT       0
`define VCP_C_TRACK       1
`define VCP_C_TWOSIDE     2
`define VCP_C_FLAT        3
`define VCP_C_CW          4
`define VCP_C_CLAMP_LO    5
`define VCP_C_INDEX       7
`define VCP_C_PROP_LO     8
`define VCP_C_FACE_LO     11
`define VCP_C_FBFIX       13
`define VCP_CTRL_RST      32'h00003C20

// Clamp control and tracking codes
`define VCP_CLAMP_OFF     2'h0
`define VCP_CLAMP_ON      2'h1
`define VCP_CLAMP_FIXED   2'h2
`define VCP_PROP_GLOW     3'h0
`define VCP_PROP_AMB      3'h1
`define VCP_PROP_DIF      3'h2
`define VCP_PROP_SPEC     3'h3
`define VCP_PROP_AMBDIF   3'h4

// Primitive types
`define VCP_PT_POINTS     4'h0
`define VCP_PT_LINES      4'h1
`define VCP_PT_LSTRIP     4'h2
`define VCP_PT_POLYGON    4'h3
`define VCP_PT_TSTRIP     4'h4
`define VCP_PT_TFAN       4'h5
`define VCP_PT_TRIS       4'h6
`define VCP_PT_QSTRIP     4'h7
`define VCP_PT_QUADS      4'h8

// Fixed point: colors Q3.12, index values Q8.8
`define VCP_FRAC          12
`define VCP_ONE           16'h1000
`define VCP_HALF          32'h00000800
`define VCP_QTR_FIVE      16'h0333
`define VCP_FOUR_FIVE     16'h0CCD
`define VCP_W_RED         16'h04CD
`define VCP_W_GRN         16'h0971
`define VCP_W_BLU         16'h01C3
`define VCP_IDX_AM_RST    16'h0000
`define VCP_IDX_DM_RST    16'h0100
`define VCP_IDX_SM_RST    16'h0100
`define VCP_IDX_RND       16'h0008

`endif

// *** tb/vcp_upstream_model.sv ***
// Upstream lighting stage model: lit colors and per-light factors.
// Assumes the bench selects a scene; outputs settle combinationally.
`timescale 1ns/100ps
`default_nettype none
module vcp_upstream_model (
  input  wire logic         scene_i,
  output logic      [63:0]  lit_front_o,
  output logic      [63:0]  lit_back_o,
  output logic      [63:0]  lit_sec_o,
  output logic      [127:0] geo_diff_o,
  output logic      [127:0] geo_spec_o
);
  // Scene 1 drives red below zero and green above one
  assign lit_front_o = scene_i ? 64'h1000_0800_1800_F000
                               : 64'h1000_1000_1000_1000;
  assign lit_sec_o   = lit_front_o;
  // Back unlike front, so a wrong face choice shows
  assign lit_back_o  = ~lit_front_o;
  // Light 0 strong, others weaker
  assign geo_diff_o  = {{7{16'h0800}}, 16'h1000};
  assign geo_spec_o  = {{7{16'h0400}}, 16'h0800};
endmodule // vcp_upstream_model
`default_nettype wire

// *** tb/vcp_color_post_props.sv ***
// Checker: bus wait state, stream latency, flat, clamp, pass-through.
// Assumes binding to the top module; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
`include "vcp_regs.vh"
module vcp_props #(parameter M_BITS = 8) (
  input wire logic        sys_clk_i,
  input wire logic        reset_n_i,
  input wire logic        hsel_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hready_i,
  input wire logic        hreadyout_o,
  input wire logic        vtx_valid_i,
  input wire logic [3:0]  prim_type_i,
  input wire logic        clip_gen_i,
  input wire logic [15:0] attr_i,
  input wire logic        out_valid_o,
  input wire logic [63:0] out_pri_o,
  input wire logic [15:0] out_attr_o,
  input wire logic        out_fixed_o,
  input wire logic        out_back_o,
  input wire logic        flat_valid_o,
  input wire logic [63:0] flat_pri_o
);
  // One clock domain
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // One wait state for every taken transfer
  property p_wait;
    hsel_i && htrans_i[1] && hready_i |=> !hreadyout_o ##1 hreadyout_o;
  endproperty
  a_wait: assert property (p_wait) else $error("bus wait state wrong");
  property p_valid;
    out_valid_o == $past(vtx_valid_i);
  endproperty
  a_valid: assert property (p_valid) else $error("output valid latency");
  // Data must hold between pulses
  property p_hold;
    !out_valid_o |-> $stable(out_pri_o);
  endproperty
  a_hold: assert property (p_hold) else $error("primary moved idle");
  property p_flat_sub;
    flat_valid_o |-> out_valid_o;
  endproperty
  a_flat_sub: assert property (p_flat_sub) else $error("stray flat");
  property p_flat_eq;
    flat_valid_o |-> flat_pri_o == out_pri_o;
  endproperty
  a_flat_eq: assert property (p_flat_eq) else $error("flat color");
  // Fixed red and alpha lanes hold k only, upper bits zero
  property p_fixed_k;
    out_valid_o && out_fixed_o |-> (out_pri_o[15:0] >> M_BITS) == 16'h0
      && (out_pri_o[63:48] >> M_BITS) == 16'h0;
  endproperty
  a_fixed_k: assert property (p_fixed_k) else $error("fixed lane wide");
  property p_attr;
    vtx_valid_i && !clip_gen_i |=> out_attr_o == $past(attr_i);
  endproperty
  a_attr: assert property (p_attr) else $error("attr changed");
  property p_front;
    vtx_valid_i && prim_type_i == `VCP_PT_POINTS |=> !out_back_o;
  endproperty
  a_front: assert property (p_front) else $error("point used back");
  c_flat: cover property (flat_valid_o);
  c_fixed: cover property (out_valid_o && out_fixed_o);
  c_clip: cover property (vtx_valid_i && clip_gen_i);
endmodule // vcp_props
bind vcp_color_post vcp_props #(.M_BITS(M_BITS)) u_props (
  .sys_clk_i, .reset_n_i, .hsel_i, .htrans_i, .hready_i, .hreadyout_o,
  .vtx_valid_i, .prim_type_i, .clip_gen_i, .attr_i, .out_valid_o,
  .out_pri_o, .out_attr_o, .out_fixed_o, .out_back_o, .flat_valid_o,
  .flat_pri_o);
`default_nettype wire

// *** tb/testbench.sv ***
// Bench: AHB-Lite and vertex stream tasks, expected values.
// Assumes upstream model supplies lit colors; one 10 MHz clock.
`timescale 1ns/100ps
`default_nettype none
`include "vcp_regs.vh"
module testbench;
  logic sys_clk_i = 1'b0, reset_n_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
  logic color_valid_i = 1'b0, vtx_valid_i = 1'b0, prim_begin_i = 1'b0;
  logic area_pos_i = 1'b0, clip_gen_i = 1'b0, attr_noper_i = 1'b0;
  logic scene = 1'b0;
  logic [1:0]   htrans_i = 2'h0;
  logic [3:0]   prim_type_i = 4'h0;
  logic [15:0]  clip_t_i = 16'h0, clip_tlin_i = 16'h0;
  logic [15:0]  attr_i = 16'h0, attr_c2_i = 16'h0;
  logic [31:0]  haddr_i = 32'h0, hwdata_i = 32'h0, rd;
  logic [63:0]  color_i = 64'h0, clip_c2_pri_i = 64'h0;
  wire logic    hreadyout_o, out_valid_o, out_fixed_o, out_back_o;
  wire logic    flat_valid_o;
  wire logic [31:0]  hrdata_o;
  wire logic [15:0]  out_attr_o;
  wire logic [11:0]  out_idx_o;
  wire logic [63:0]  out_pri_o, out_sec_o, flat_pri_o;
  wire logic [63:0]  lit_front_i, lit_back_i, lit_sec_i;
  wire logic [127:0] geo_diff_i, geo_spec_i;
  int fail_count = 0, checks_done = 0, cyc = 0;
  // Provoking masks by primitive, vertex 1 in bit 0
  logic [5:0] mask [9] = '{6'h3F, 6'h2A, 6'h3E, 6'h01, 6'h3C,
                           6'h3C, 6'h24, 6'h28, 6'h08};
  // Clamp control words and expected fixed flag
  logic [31:0] cl [4] = '{32'h3C21, 32'h3C01, 32'h1C41, 32'h3C41};
  logic        fx [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

  vcp_upstream_model u_up (.scene_i(scene), .lit_front_o(lit_front_i),
    .lit_back_o(lit_back_i), .lit_sec_o(lit_sec_i),
    .geo_diff_o(geo_diff_i), .geo_spec_o(geo_spec_i));

  // Tied: second clip secondary color and index, integer color path
  vcp_color_post DUT (.sys_clk_i, .reset_n_i, .hsel_i, .haddr_i,
    .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i,
    .hready_i(hreadyout_o), .hreadyout_o, .hrdata_o, .hresp_o(),
    .color_valid_i, .color_i, .vtx_valid_i, .prim_begin_i, .prim_type_i,
    .area_pos_i, .lit_front_i, .lit_back_i, .lit_sec_i, .geo_diff_i,
    .geo_spec_i, .clip_gen_i, .clip_t_i, .clip_tlin_i, .clip_c2_pri_i,
    .clip_c2_sec_i(64'h0), .clip_c2_idx_i(16'h0), .attr_i, .attr_c2_i,
    .attr_noper_i, .int_src_i(1'b0), .int_color_i(32'h0), .out_valid_o,
    .out_pri_o, .out_sec_o, .out_idx_o, .out_attr_o, .out_fixed_o,
    .out_back_o, .flat_valid_o, .flat_pri_o, .flat_sec_o(),
    .flat_idx_o());

  initial forever #50 sys_clk_i = ~sys_clk_i;

  // Hang guard
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fail_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  // Single transfer, waits on hready
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, {32'h0, e}, {32'h0, rd});
  endtask

  // One vertex; returns once its output settled
  task automatic vtx(input logic [3:0] t, input logic b);
    @(posedge sys_clk_i);
    vtx_valid_i <= 1'b1;
    prim_type_i <= t;
    prim_begin_i <= b;
    area_pos_i <= ~area_pos_i;
    @(posedge sys_clk_i);
    vtx_valid_i <= 1'b0;
    #1;
  endtask

  initial
  begin
    repeat (5) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    rdchk("ctrl", `VCP_CTRL_OFS, 32'h3C20);
    rdchk("am", `VCP_IDX_AM_OFS, 32'h0);
    rdchk("dm", `VCP_IDX_DM_OFS, 32'h100);
    rdchk("sm", `VCP_IDX_SM_OFS, 32'h100);
    rdchk("hole", 8'h3C, 32'h0);
    // Track front ambient, then retarget to diffuse
    bus(1'b1, `VCP_CTRL_OFS, 32'h2922);
    @(posedge sys_clk_i);
    color_i <= 64'h1000_0400_0800_0C00;
    color_valid_i <= 1'b1;
    @(posedge sys_clk_i);
    color_valid_i <= 1'b0;
    bus(1'b1, `VCP_MAT_SEL_OFS, 32'h1);
    rdchk("trk amb", `VCP_MAT_RG_OFS, 32'h0800_0C00);
    bus(1'b1, `VCP_MAT_RG_OFS, 32'h0);
    rdchk("trk keep", `VCP_MAT_RG_OFS, 32'h0800_0C00);
    bus(1'b1, `VCP_CTRL_OFS, 32'h2A22);
    bus(1'b1, `VCP_MAT_SEL_OFS, 32'h2);
    rdchk("trk new", `VCP_MAT_RG_OFS, 32'h0800_0C00);
    bus(1'b1, `VCP_CTRL_OFS, 32'h2A20);
    rdchk("persist", `VCP_MAT_RG_OFS, 32'h0800_0C00);
    bus(1'b1, `VCP_MAT_RG_OFS, 32'h0);
    rdchk("mat wr", `VCP_MAT_RG_OFS, 32'h0);
    // Every clamp code with out-of-range lit colors
    @(posedge sys_clk_i);
    scene <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b1, `VCP_CTRL_OFS, cl[k]);
      vtx(`VCP_PT_POINTS, 1'b1);
      chk("fixed", fx[k], out_fixed_o);
      chk("r", fx[k] ? 64'h0 : 64'hF000, out_pri_o[15:0]);
      chk("g", fx[k] ? 64'hFF : 64'h1800, out_pri_o[31:16]);
      chk("sec g", fx[k] ? 64'hFF : 64'h1800, out_sec_o[31:16]);
    end
    // Clipped vertex blends; unclipped passes untouched
    bus(1'b1, `VCP_CTRL_OFS, 32'h3C01);
    @(posedge sys_clk_i);
    scene <= 1'b0;
    clip_gen_i <= 1'b1;
    clip_t_i <= 16'h0800;
    clip_tlin_i <= 16'h0400;
    clip_c2_pri_i <= 64'h0800_0800_0800_0800;
    attr_i <= 16'h1000;
    attr_noper_i <= 1'b1;
    vtx(`VCP_PT_TRIS, 1'b1);
    chk("clip", 64'h0C00_0C00_0C00_0C00, out_pri_o);
    chk("clip attr", 64'h0400, out_attr_o);
    chk("no flat", 64'h0, flat_valid_o);
    @(posedge sys_clk_i);
    clip_gen_i <= 1'b0;
    vtx(`VCP_PT_TRIS, 1'b1);
    chk("inside", 64'h1000_1000_1000_1000, out_pri_o);
    // Flat shading and two-sided face choice on every kind
    bus(1'b1, `VCP_CTRL_OFS, 32'h3C2D);
    for (int t = 0; t < 9; t++)
      for (int v = 0; v < 6; v++)
      begin
        vtx(t[3:0], v == 0);
        chk("flat", mask[t][v], flat_valid_o);
        chk("back", t >= 3 && !area_pos_i, out_back_o);
      end
    // Unlit index mode: index 12.0 must come out exact
    bus(1'b1, `VCP_CTRL_OFS, 32'h3CA0);
    vtx(`VCP_PT_POINTS, 1'b1);
    chk("idx", 64'h0C0, out_idx_o);
    stop_test();
  end
endmodule // testbench
`default_nettype wire
